//--- src/accumulator_load_unit.sv
// Accumulator load datapath: four loads, stack push and status flags
`timescale 1ns/1ns
`default_nettype none
module accumulator_load_unit #(
    parameter int WMEM_DEPTH = acc_load_pkg::WMEM_DEPTH_DEF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Sequencer request
    input wire logic i_start,
    input wire acc_load_pkg::load_op_t i_op,
    input wire acc_load_pkg::src_t i_src,
    input wire logic [15:0] i_addr,
    input wire logic [31:0] i_const,
    input wire acc_load_pkg::area_t i_area,
    input wire logic [5:0] i_bit_count,
    input wire logic [23:0] i_octal,
    input wire logic i_store,
    input wire logic i_scan_end,
    // Word memory
    output logic o_wmem_rd,
    output logic [15:0] o_wmem_addr,
    input wire logic [15:0] i_wmem_data,
    // Bit memory
    output logic o_bmem_rd,
    output acc_load_pkg::area_t o_bmem_area,
    output logic [10:0] o_bmem_addr,
    input wire logic i_bmem_bit,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic o_operand_err,
    output logic [31:0] o_acc,
    output logic [31:0] o_stack_top,
    output logic o_pointer_range_flag,
    output logic o_negative_result_flag,
    output logic o_zero_load_flag
);
    import acc_load_pkg::*;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_ptr = 3'h1,
        st_wlo = 3'h2,
        st_whi = 3'h3,
        st_bit = 3'h4
    } state_t;

    typedef struct packed {
        state_t st;
        logic ph;
        load_op_t op;
        logic dbl;
        logic [15:0] off, lo, waddr;
        area_t area;
        logic [10:0] baddr;
        logic [5:0] cnt, idx;
        logic [31:0] bits;
        logic loaded;
        logic [31:0] acc;
        logic wrd, brd, busy, done, err, prf, nf, zf;
    } core_t;

    core_t s_q;
    core_t s_d;
    logic push, wr_en, fail, oct_bad;
    logic [31:0] wr_val, new_bits, level1;
    logic [16:0] ea;
    logic [11:0] bit_last;
    logic [15:0] oct_val;

    // Word address plus second word for double loads must fit the memory
    function automatic logic addr_ok(input logic [16:0] a, input logic dbl);
        return ({1'b0, a} + {17'h00000, dbl}) < 18'(WMEM_DEPTH);
    endfunction

    octal_to_bin #(.DIGITS(OCT_DIGITS)) octal_to_bin_i (
        .i_digits(i_octal),
        .o_value(oct_val),
        .o_bad(oct_bad)
    );

    acc_stack #(.DEPTH(STACK_DEPTH), .W(ACC_W)) acc_stack_i (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_push(push),
        .i_data(s_q.acc),
        .o_level1(level1)
    );

    // Last bit must stay inside its area
    assign bit_last = {1'b0, i_addr[10:0]} + {6'h00, i_bit_count} - 12'h001;
    // Each bit lands at the next higher position
    assign new_bits = s_q.bits | ({31'h0, i_bmem_bit} << s_q.idx);

    always_comb begin
        s_d = s_q;
        wr_en = 1'b0;
        wr_val = '0;
        fail = 1'b0;
        push = 1'b0;
        ea = '0;
        s_d.wrd = 1'b0;
        s_d.brd = 1'b0;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        unique case (s_q.st)
            st_idle: begin
                if (i_scan_end) begin
                    s_d.acc = '0;
                    s_d.loaded = 1'b0;
                end
                if (i_store) begin
                    s_d.loaded = 1'b0;
                end
                if (i_start) begin
                    s_d.op = i_op;
                    s_d.dbl = (i_op == double_word_load_op);
                    s_d.area = i_area;
                    s_d.baddr = i_addr[10:0];
                    s_d.cnt = i_bit_count;
                    s_d.idx = '0;
                    s_d.bits = '0;
                    s_d.ph = 1'b0;
                    s_d.busy = 1'b1;
                    s_d.off = s_d.loaded ? s_q.acc[15:0] : level1[15:0];
                    unique case (i_op)
                        double_word_load_op: begin
                            if (i_src == src_const) begin
                                s_d.err = (i_const > DWORD_CONST_MAX);
                                wr_en = !s_d.err;
                                wr_val = i_const;
                            end else if (i_src == src_ptr) begin
                                s_d.wrd = 1'b1;
                                s_d.waddr = i_addr;
                                s_d.st = st_ptr;
                            end else if (addr_ok({1'b0, i_addr}, 1'b1)) begin
                                s_d.wrd = 1'b1;
                                s_d.waddr = i_addr;
                                s_d.st = st_wlo;
                            end else begin
                                s_d.err = 1'b1;
                            end
                        end
                        bitfield_load_op: begin
                            // Count one to 32, area bounds
                            s_d.err = !(i_bit_count >= BIT_CNT_MIN && i_bit_count <= BIT_CNT_MAX
                                && i_addr[15:11] == 5'h00
                                && bit_last <= {1'b0, area_max(i_area)});
                            s_d.brd = !s_d.err;
                            s_d.st = st_bit;
                        end
                        octal_to_hex_load_op: begin
                            s_d.err = oct_bad;
                            wr_en = !oct_bad;
                            wr_val = {16'h0000, oct_val};
                        end
                        indexed_load_op: begin
                            ea = {1'b0, i_addr} + {1'b0, s_d.off};
                            if (i_src == src_ptr) begin
                                s_d.wrd = 1'b1;
                                s_d.waddr = i_addr;
                                s_d.st = st_ptr;
                            end else if (addr_ok(ea, 1'b0)) begin
                                s_d.wrd = 1'b1;
                                s_d.waddr = ea[15:0];
                                s_d.st = st_wlo;
                            end else begin
                                s_d.err = 1'b1;
                            end
                        end
                    endcase
                end
            end
            st_ptr: begin
                s_d.ph = 1'b1;
                if (s_q.ph) begin
                    // Pointer value is the word address; indexed loads add the offset
                    ea = {1'b0, i_wmem_data};
                    if (s_q.op == indexed_load_op) begin
                        ea = ea + {1'b0, s_q.off};
                    end
                    if (addr_ok(ea, s_q.dbl)) begin
                        s_d.wrd = 1'b1;
                        s_d.waddr = ea[15:0];
                        s_d.ph = 1'b0;
                        s_d.st = st_wlo;
                    end else begin
                        fail = 1'b1;
                        s_d.prf = 1'b1;
                    end
                end
            end
            st_wlo: begin
                s_d.ph = 1'b1;
                if (s_q.ph) begin
                    s_d.lo = i_wmem_data;
                    if (s_q.dbl) begin
                        s_d.wrd = 1'b1;
                        s_d.waddr = s_q.waddr + 16'h0001;
                        s_d.ph = 1'b0;
                        s_d.st = st_whi;
                    end else begin
                        wr_en = 1'b1;
                        wr_val = {16'h0000, i_wmem_data};
                    end
                end
            end
            st_whi: begin
                s_d.ph = 1'b1;
                if (s_q.ph) begin
                    wr_en = 1'b1;
                    wr_val = {i_wmem_data, s_q.lo};
                end
            end
            st_bit: begin
                s_d.ph = 1'b1;
                if (s_q.ph) begin
                    s_d.bits = new_bits;
                    if (s_q.idx == s_q.cnt - 6'h01) begin
                        wr_en = 1'b1;
                        wr_val = new_bits;
                    end else begin
                        s_d.idx = s_q.idx + 6'h01;
                        s_d.baddr = s_q.baddr + 11'h001;
                        s_d.brd = 1'b1;
                        s_d.ph = 1'b0;
                    end
                end
            end
            default: s_d.st = st_idle;
        endcase
        if (wr_en) begin
            // Push when a load is pending
            push = s_d.loaded;
            s_d.acc = wr_val;
            s_d.loaded = 1'b1;
            s_d.prf = 1'b0;
            s_d.nf = wr_val[31];
            s_d.zf = (wr_val == 32'h00000000);
        end
        if (wr_en || fail || s_d.err) begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = st_idle;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_wmem_rd = s_q.wrd;
    assign o_wmem_addr = s_q.waddr;
    assign o_bmem_rd = s_q.brd;
    assign o_bmem_area = s_q.area;
    assign o_bmem_addr = s_q.baddr;
    assign o_busy = s_q.busy;
    assign o_done = s_q.done;
    assign o_operand_err = s_q.err;
    assign o_acc = s_q.acc;
    assign o_stack_top = level1;
    assign o_pointer_range_flag = s_q.prf;
    assign o_negative_result_flag = s_q.nf;
    assign o_zero_load_flag = s_q.zf;

    AST_DWORD_CONST: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.st == st_idle && i_start && i_op == double_word_load_op && i_src == src_const
        && i_const <= DWORD_CONST_MAX |=> s_q.done && s_q.acc == $past(i_const))
        else $error("double constant load wrong");
    AST_PTR_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.st == st_ptr && s_q.ph && !addr_ok(ea, s_q.dbl)
        |=> s_q.prf && s_q.done && !s_q.busy)
        else $error("pointer range flag missing");
    AST_NEG_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.done && !s_q.err && !s_q.prf |-> s_q.nf == s_q.acc[31])
        else $error("negative flag wrong");
    AST_ZERO_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.done && !s_q.err && !s_q.prf |-> s_q.zf == (s_q.acc == 32'h00000000))
        else $error("zero flag wrong");
    AST_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
        push |=> level1 == $past(s_q.acc) && s_q.loaded)
        else $error("stack push lost value");
    AST_BIT_UPPER: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.done && !s_q.err && s_q.op == bitfield_load_op
        |-> (s_q.acc >> s_q.cnt) == 32'h00000000)
        else $error("bits above count not cleared");
    AST_OCTAL: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.st == st_idle && i_start && i_op == octal_to_hex_load_op && !oct_bad
        |=> s_q.acc == {16'h0000, $past(oct_val)})
        else $error("octal conversion wrong");
    AST_INDEX_UPPER: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.done && !s_q.err && !s_q.prf && s_q.op == indexed_load_op
        |-> s_q.acc[31:16] == 16'h0000)
        else $error("indexed upper half not cleared");
    AST_BIT_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.st == st_bit && s_q.ph && s_q.idx == 6'h00
        |=> (s_q.done ? s_q.acc[0] : s_q.bits[0]) == $past(i_bmem_bit))
        else $error("first bit not in bit zero");
    AST_FINISH: assert property (@(posedge i_clk) disable iff (i_rst)
        s_q.st == st_idle && i_start |=> ##[0:98] s_q.done)
        else $error("load did not finish in time");

endmodule
`default_nettype wire

//--- src/acc_load_pkg.sv
// Shared types and constants of the accumulator load datapath
package acc_load_pkg;

    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int BIT_ADDR_W = 11;
    localparam int CNT_W = 6;
    localparam int STACK_DEPTH = 8;
    localparam int OCT_DIGITS = 6;

    // Plain default for the word memory size, in words
    localparam int WMEM_DEPTH_DEF = 16384;

    localparam logic [31:0] DWORD_CONST_MAX = 32'h0fffffff;
    localparam logic [5:0] BIT_CNT_MIN = 6'h01;
    localparam logic [5:0] BIT_CNT_MAX = 6'h20;

    // Highest bit address of each discrete area (777, 1777, 377, 177 octal)
    localparam logic [10:0] IO_BIT_MAX = 11'h1ff;
    localparam logic [10:0] RELAY_BIT_MAX = 11'h3ff;
    localparam logic [10:0] TMR_BIT_MAX = 11'h0ff;
    localparam logic [10:0] CTR_BIT_MAX = 11'h07f;

    typedef enum logic [1:0] {
        double_word_load_op = 2'h0,
        bitfield_load_op = 2'h1,
        octal_to_hex_load_op = 2'h2,
        indexed_load_op = 2'h3
    } load_op_t;

    typedef enum logic [1:0] {
        src_vmem = 2'h0,
        src_ptr = 2'h1,
        src_const = 2'h2
    } src_t;

    typedef enum logic [2:0] {
        area_in = 3'h0,
        area_out = 3'h1,
        area_spec = 3'h2,
        area_relay = 3'h3,
        area_stage = 3'h4,
        area_tmr = 3'h5,
        area_ctr = 3'h6
    } area_t;

    function automatic logic [10:0] area_max(input area_t a);
        logic [10:0] m;
        m = 11'h000;
        case (a)
            area_in, area_out, area_spec: m = IO_BIT_MAX;
            area_relay, area_stage: m = RELAY_BIT_MAX;
            area_tmr: m = TMR_BIT_MAX;
            area_ctr: m = CTR_BIT_MAX;
            default: m = 11'h000;
        endcase
        return m;
    endfunction

endpackage

//--- src/acc_stack.sv
// Eight-level accumulator stack, push only
`timescale 1ns/1ns
`default_nettype none
module acc_stack #(
    parameter int DEPTH = acc_load_pkg::STACK_DEPTH,
    parameter int W = acc_load_pkg::ACC_W
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Push port
    input wire logic i_push,
    input wire logic [W-1:0] i_data,
    // First level
    output logic [W-1:0] o_level1
);
    import acc_load_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] lvl;
    } stack_t;

    stack_t s_q;
    stack_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                s_d.lvl[i] = s_q.lvl[i-1];
            end
            s_d.lvl[0] = i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level1 = s_q.lvl[0];

    AST_STACK_SHIFT: assert property (@(posedge i_clk) disable iff (i_rst)
        i_push |=> s_q.lvl[0] == $past(i_data) && s_q.lvl[DEPTH-1] == $past(s_q.lvl[DEPTH-2]))
        else $error("stack levels not shifted down");

endmodule
`default_nettype wire

//--- src/octal_to_bin.sv
// Converts nibble-coded octal digits to a 16-bit binary value
`timescale 1ns/1ns
`default_nettype none
module octal_to_bin #(
    parameter int DIGITS = acc_load_pkg::OCT_DIGITS
) (
    // Digits, most significant nibble first
    input wire logic [4*DIGITS-1:0] i_digits,
    // Result
    output logic [15:0] o_value,
    output logic o_bad
);
    import acc_load_pkg::*;

    logic [3*DIGITS-1:0] v;

    always_comb begin
        v = '0;
        o_bad = 1'b0;
        for (int i = DIGITS - 1; i >= 0; i--) begin
            v = {v[3*DIGITS-4:0], i_digits[4*i +: 3]};
            o_bad = o_bad | i_digits[4*i+3];
        end
        // Values past 16 bits cannot be held
        o_bad = o_bad | (|v[3*DIGITS-1:16]);
        o_value = v[15:0];
    end

endmodule
`default_nettype wire

//--- verif/load_mem_model.sv
// Word and bit memory model that answers the load unit's read strobes
`timescale 1ns/1ns
`default_nettype none
module load_mem_model #(
    parameter int DEPTH = 64
) (
    // Clock
    input wire logic i_clk,
    // Word port
    input wire logic i_wmem_rd,
    input wire logic [15:0] i_wmem_addr,
    output logic [15:0] o_wmem_data,
    // Bit port
    input wire logic i_bmem_rd,
    input wire logic [2:0] i_bmem_area,
    input wire logic [10:0] i_bmem_addr,
    output logic o_bmem_bit
);
    logic [15:0] wmem [DEPTH];
    logic bmem [7][2048];

    initial begin
        o_wmem_data = 16'h0000;
        o_bmem_bit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            wmem[i] = 16'h0000;
        end
        for (int a = 0; a < 7; a++) begin
            for (int b = 0; b < 2048; b++) begin
                bmem[a][b] = b[0] ^ b[3] ^ b[6] ^ a[0];
            end
        end
    end

    // Valid only in the cycle after the strobe; inverted otherwise so stale data shows
    always @(posedge i_clk) begin
        if (i_wmem_rd) begin
            o_wmem_data <= wmem[i_wmem_addr % DEPTH];
        end else begin
            o_wmem_data <= ~o_wmem_data;
        end
        if (i_bmem_rd) begin
            o_bmem_bit <= bmem[i_bmem_area % 7][i_bmem_addr];
        end else begin
            o_bmem_bit <= ~o_bmem_bit;
        end
    end
endmodule
`default_nettype wire

//--- verif/accumulator_load_unit_tb.sv
// Self-checking bench of the accumulator load unit
`timescale 1ns/1ns
`default_nettype none
module accumulator_load_unit_tb;
    import acc_load_pkg::*;
    localparam int DEPTH = 64;
    localparam logic [10:0] AMAX [7] = '{11'h1ff, 11'h1ff, 11'h1ff, 11'h3ff, 11'h3ff, 11'h0ff,
                                          11'h07f};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    load_op_t op = double_word_load_op;
    src_t src = src_const;
    logic [15:0] addr = 16'h0000;
    logic [31:0] cst = 32'h00000000;
    area_t area = area_in;
    logic [5:0] cnt = 6'h01;
    logic [23:0] octal = 24'h000000;
    logic store = 1'b0;
    logic scan_end = 1'b0;
    logic wrd, brd, bbit, busy, done, err, prf, nf, zf;
    logic [15:0] waddr, wdata;
    logic [10:0] baddr;
    area_t barea;
    logic [31:0] acc, top;
    int n_errors = 0;
    int checks = 0;
    int lat;

    always #10 clk = ~clk;

    accumulator_load_unit #(.WMEM_DEPTH(DEPTH)) accumulator_load_unit_i (
        .i_clk(clk), .i_rst(rst), .i_start(start), .i_op(op), .i_src(src), .i_addr(addr),
        .i_const(cst), .i_area(area), .i_bit_count(cnt), .i_octal(octal), .i_store(store),
        .i_scan_end(scan_end), .o_wmem_rd(wrd), .o_wmem_addr(waddr), .i_wmem_data(wdata),
        .o_bmem_rd(brd), .o_bmem_area(barea), .o_bmem_addr(baddr), .i_bmem_bit(bbit),
        .o_busy(busy), .o_done(done), .o_operand_err(err), .o_acc(acc), .o_stack_top(top),
        .o_pointer_range_flag(prf), .o_negative_result_flag(nf), .o_zero_load_flag(zf));

    load_mem_model #(.DEPTH(DEPTH)) load_mem_model_i (
        .i_clk(clk), .i_wmem_rd(wrd), .i_wmem_addr(waddr), .o_wmem_data(wdata),
        .i_bmem_rd(brd), .i_bmem_area(barea), .i_bmem_addr(baddr), .o_bmem_bit(bbit));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Flags as {pointer range, negative, zero}
    task automatic flags(input logic [2:0] exp);
        chk("flags", {29'h0, exp}, {29'h0, prf, nf, zf});
    endtask

    // One request; returns at the falling edge where done is seen
    task automatic run(input load_op_t p, input src_t s, input logic [15:0] a,
                       input logic [31:0] k, input area_t ar, input logic [5:0] c,
                       input logic [23:0] o);
        @(negedge clk);
        op = p;
        src = s;
        addr = a;
        cst = k;
        area = ar;
        cnt = c;
        octal = o;
        start = 1'b1;
        lat = 0;
        do begin
            @(negedge clk);
            start = 1'b0;
            lat++;
        end while (done !== 1'b1 && lat < 400);
        chk("done", 32'h1, {31'h0, done}); // answer came
        chk("busy", 32'h0, {31'h0, busy}); // released
    endtask

    task automatic ldk(input logic [31:0] k);
        run(double_word_load_op, src_const, 16'h0000, k, area_in, 6'h01, 24'h0);
    endtask

    task automatic side(input logic st, input logic se);
        @(negedge clk);
        store = st;
        scan_end = se;
        @(negedge clk);
        store = 1'b0;
        scan_end = 1'b0;
    endtask

    task automatic t_double();
        load_mem_model_i.wmem[10] = 16'h5678;
        load_mem_model_i.wmem[11] = 16'h9234;
        run(double_word_load_op, src_vmem, 16'h000a, 32'h0, area_in, 6'h01, 24'h0);
        chk("double lat", 32'd5, lat); // latency
        chk("double acc", 32'h92345678, acc); // word order
        flags(3'b010); // sign set
        ldk(32'h00000000);
        chk("zero acc", 32'h0, acc); // constant
        flags(3'b001); // zero load
        ldk(32'h0fffffff);
        flags(3'b000); // cleared
        ldk(32'h10000000);
        chk("const err", 32'h1, {31'h0, err}); // range
        chk("const keep", 32'h0fffffff, acc); // unchanged
        run(double_word_load_op, src_vmem, 16'(DEPTH - 1), 32'h0, area_in, 6'h01, 24'h0);
        chk("top err", 32'h1, {31'h0, err}); // last word
    endtask

    task automatic t_push();
        ldk(32'h11);
        ldk(32'h22);
        chk("push", 32'h11, top); // pushed
        side(1'b1, 1'b0);
        ldk(32'h33);
        chk("store", 32'h11, top); // no push
        side(1'b0, 1'b1);
        chk("scan", 32'h0, acc); // cleared
        ldk(32'h44);
        ldk(32'h55);
        chk("push2", 32'h44, top); // level one
    endtask

    task automatic t_bits();
        logic [31:0] e;
        logic [10:0] s;
        for (int a = 0; a < 7; a++) begin
            s = AMAX[a] - 11'd31;
            e = '0;
            for (int i = 0; i < 32; i++) begin
                e[i] = load_mem_model_i.bmem[a][s + i];
            end
            run(bitfield_load_op, src_vmem, {5'h0, s}, 32'h0, area_t'(a), 6'h20, 24'h0);
            chk("bits", e, acc); // area end
            chk("bits lat", 32'd65, lat); // count
            flags({1'b0, e[31], e == 32'h0}); // flags
            run(bitfield_load_op, src_vmem, {5'h0, s + 11'd1}, 32'h0, area_t'(a), 6'h20, 24'h0);
            chk("area err", 32'h1, {31'h0, err}); // past end
        end
        run(bitfield_load_op, src_vmem, 16'h0006, 32'h0, area_relay, 6'h05, 24'h0);
        chk("bits5", {27'h0, 5'b01001}, acc); // upper zero
        run(bitfield_load_op, src_vmem, 16'h0000, 32'h0, area_in, 6'h00, 24'h0);
        chk("cnt0", 32'h1, {31'h0, err}); // zero count
        run(bitfield_load_op, src_vmem, 16'h0000, 32'h0, area_in, 6'h21, 24'h0);
        chk("cnt33", 32'h1, {31'h0, err}); // count high
    endtask

    task automatic t_octal();
        run(octal_to_hex_load_op, src_const, 16'h0, 32'h0, area_in, 6'h01, 24'h040400);
        chk("oct", 32'h4100, acc); // conversion
        run(octal_to_hex_load_op, src_const, 16'h0, 32'h0, area_in, 6'h01, 24'h177777);
        chk("oct max", 32'hffff, acc); // sixteen bits
        run(octal_to_hex_load_op, src_const, 16'h0, 32'h0, area_in, 6'h01, 24'h000000);
        flags(3'b001); // zero
        run(octal_to_hex_load_op, src_const, 16'h0, 32'h0, area_in, 6'h01, 24'h000018);
        chk("oct digit", 32'h1, {31'h0, err}); // bad digit
        run(octal_to_hex_load_op, src_const, 16'h0, 32'h0, area_in, 6'h01, 24'h200000);
        chk("oct big", 32'h1, {31'h0, err}); // too wide
    endtask

    task automatic t_index();
        load_mem_model_i.wmem[29] = 16'hc345;
        ldk(32'h15);
        run(indexed_load_op, src_vmem, 16'h0008, 32'h0, area_in, 6'h01, 24'h0);
        chk("index", 32'h0000c345, acc); // base plus offset
        chk("index top", 32'h15, top); // offset pushed
        flags(3'b000); // upper cleared
        load_mem_model_i.wmem[3] = 16'h0002;
        load_mem_model_i.wmem[6] = 16'h8001;
        ldk(32'h4);
        run(indexed_load_op, src_ptr, 16'h0003, 32'h0, area_in, 6'h01, 24'h0);
        chk("index ptr", 32'h8001, acc); // pointer base
        ldk(32'h100);
        run(indexed_load_op, src_ptr, 16'h0003, 32'h0, area_in, 6'h01, 24'h0);
        chk("index out", 32'h100, acc); // unchanged
        chk("index prf", 32'h1, {31'h0, prf}); // flag set
    endtask

    task automatic t_ptr();
        load_mem_model_i.wmem[4] = 16'h0014;
        load_mem_model_i.wmem[20] = 16'h1111;
        load_mem_model_i.wmem[21] = 16'h0001;
        load_mem_model_i.wmem[5] = 16'h0040;
        run(double_word_load_op, src_ptr, 16'h0004, 32'h0, area_in, 6'h01, 24'h0);
        chk("ptr acc", 32'h00011111, acc); // pointer word
        chk("ptr lat", 32'd7, lat); // timing
        flags(3'b000); // cleared
        run(double_word_load_op, src_ptr, 16'h0005, 32'h0, area_in, 6'h01, 24'h0);
        chk("ptr err", 32'h0, {31'h0, err}); // no refusal
        chk("ptr flag", 32'h1, {31'h0, prf}); // out of range
        chk("ptr keep", 32'h00011111, acc); // unchanged
    endtask

    task automatic close_out();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Tests need about 600 cycles; margin for a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk("reset acc", 32'h0, acc);
        flags(3'b000);
        t_double();
        t_push();
        t_bits();
        t_octal();
        t_index();
        t_ptr();
        close_out();
    end
endmodule
`default_nettype wire
